// File: esm_params.svh
// esm_params.svh: command codes, field positions, reset values and timing for the eeprom serial master
// assumes it is included by bare name from the design files
`ifndef ESM_PARAMS_SVH
`define ESM_PARAMS_SVH
`define ESM_CLK_HZ 10000000
`define ESM_TW_SCK_HZ 78000
`define ESM_3W_SCK_HZ 500000
`define ESM_CMD_NOP 4'h0
`define ESM_CMD_RX_ACK 4'h2
`define ESM_CMD_TX 4'h3
`define ESM_CMD_STOP 4'h5
`define ESM_CMD_RX_LAST 4'h6
`define ESM_CMD_START 4'h9
`define ESM_PINSEL_TWO 2'h1
`define ESM_PINSEL_THREE 2'h3
`define ESM_BIT_WFR 7
`define ESM_BIT_HIZ 5
`define ESM_BIT_RD 4
`define ESM_CNT_MAX 4'h8
`define ESM_ACK_N_RST 1'b1
`define ESM_SCK_RST 1'b1
`define ESM_FIFO_DEPTH 2
`endif

// File: esm_pkg.sv
// esm_pkg: state and register types of the eeprom serial master
// assumes nothing beyond a SystemVerilog compiler
package esm_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_STOP, ST_BYTE, ST_TW, ST_WAIT} esm_state_e;
   typedef struct packed {
      esm_state_e state;
      logic busy;
      logic error;
      logic rx_ack_n;
      logic tx_ack_n;
      logic clk_run;
      logic sck;
      logic sd_out;
      logic sd_oe;
      logic irq;
      logic [1:0] step;
      logic [3:0] bit_idx;
      logic [7:0] div;
      logic [7:0] sh;
      logic [7:0] data_buf;
      logic [7:0] cmd;
      logic [7:0] ctrl_rd;
   } esm_regs_s;
endpackage : esm_pkg

// File: esm_fifo.sv
// esm_fifo: small buffer with valid and ready on both sides
// assumes one clock and a synchronous active-high reset; DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none
`include "esm_params.svh"
module esm_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = `ESM_FIFO_DEPTH
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_slot
         always_ff @(posedge clk)
         begin
            if (push && (wr_ptr_reg == AW'(gi)))
               mem_reg[gi] <= in_data;
         end
      end
   endgenerate
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         if (pop)
            rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
         if (push && !pop)
            count_reg <= (AW+1)'(count_reg + 1'b1);
         else if (pop && !push)
            count_reg <= (AW+1)'(count_reg - 1'b1);
      end
   end
endmodule : esm_fifo
`default_nettype wire

// File: esm_eeprom_serial_master.sv
// esm_eeprom_serial_master: two-wire and three-wire serial master for an external eeprom
// assumes a 10 MHz REF_CLK, an outside pull-up on the data pin and pin muxing outside
`timescale 1ns/1ps
`default_nettype none
`include "esm_params.svh"
//
// Function
// - two-wire mode drives pins four and five
// - data then transmit code launches byte
// - busy during operation, interrupt on fall
// - received byte left in data buffer
// - 78kHz clock, held high when stopped
// - error bit7, busy bit6, reset zero
// - ack bits 5,4 active low, reset one
// - no-op, start and stop stop clock; a finished byte leaves it toggling
// - receive with ack, last without ack
// - start and stop conditions generated
// - illegal code sets error, no operation
// - select value 3 gives 500kHz three-wire
// - three-wire write launches up to 8 bits
// - count bits, msb first, read right-justified
// - float bit and read bit select
// - wait for data rise before busy falls, with wait and float bits both set
// - zero count: no clocks, line obeys float
module esm_eeprom_serial_master
   import esm_pkg::*;
#(
   parameter int unsigned CLK_HZ = `ESM_CLK_HZ,
   parameter int unsigned TW_HZ = `ESM_TW_SCK_HZ,
   parameter int unsigned W3_HZ = `ESM_3W_SCK_HZ,
   parameter int unsigned FIFO_DEPTH = `ESM_FIFO_DEPTH
)(
   // clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   // pin function selection
   input wire logic [1:0] PIN_FUNC_SEL,
   // control and status register
   input wire logic CTRL_WR,
   input wire logic [7:0] CTRL_WDATA,
   output logic [7:0] CTRL_RDATA,
   // serial data buffer
   input wire logic DATA_WR,
   input wire logic [7:0] DATA_WDATA,
   output logic DATA_WR_RDY,
   output logic [7:0] DATA_RDATA,
   // pins
   output logic GEN_PIN_FOUR_OUT,
   output logic GEN_PIN_FOUR_OE,
   input wire logic GEN_PIN_FIVE_IN,
   output logic GEN_PIN_FIVE_OUT,
   output logic GEN_PIN_FIVE_OE,
   // completion event
   output logic EXT_SERIAL_INT
);
   localparam logic [7:0] TW_RELOAD = 8'(CLK_HZ / (2 * TW_HZ) - 1);
   localparam logic [7:0] W3_RELOAD = 8'(CLK_HZ / (2 * W3_HZ) - 1);

   function automatic logic cmd_legal(input logic [3:0] c);
      cmd_legal = (c == `ESM_CMD_NOP) || (c == `ESM_CMD_RX_ACK) || (c == `ESM_CMD_TX) ||
                  (c == `ESM_CMD_STOP) || (c == `ESM_CMD_RX_LAST) || (c == `ESM_CMD_START);
   endfunction : cmd_legal

   esm_regs_s r_reg;
   esm_regs_s r_next;
   logic sd_s1_reg;
   logic sd_s2_reg;
   logic sd_s3_reg;
   logic sd_filt_reg;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic pop;

   // pin input passes three flops; a change counts once the last two agree
   wire sd_filt_next = (sd_s2_reg == sd_s3_reg) ? sd_s2_reg : sd_filt_reg;
   wire sda = sd_filt_reg;
   wire sda_rise = sd_filt_next && !sd_filt_reg;
   wire mode_two = (PIN_FUNC_SEL == `ESM_PINSEL_TWO);
   wire mode_three = (PIN_FUNC_SEL == `ESM_PINSEL_THREE);
   wire mode_on = mode_two || mode_three;
   wire take = CTRL_WR && !r_reg.busy;
   wire [3:0] wcmd = CTRL_WDATA[3:0];
   wire tick = (r_reg.div == 8'h00);
   wire [7:0] src = fifo_valid ? fifo_data : r_reg.data_buf;
   wire is_tx = (r_reg.cmd[3:0] == `ESM_CMD_TX);
   wire rx_with_ack = (r_reg.cmd[3:0] == `ESM_CMD_RX_ACK);
   wire tw_rd = r_reg.cmd[`ESM_BIT_RD];
   wire tw_hiz = r_reg.cmd[`ESM_BIT_HIZ];
   wire tw_wfr = r_reg.cmd[`ESM_BIT_WFR] && tw_hiz;
   wire [3:0] tw_cnt = (r_reg.cmd[3:0] > `ESM_CNT_MAX) ? `ESM_CNT_MAX : r_reg.cmd[3:0];
   wire [3:0] idx_inc = 4'(r_reg.bit_idx + 4'h1);

   assign GEN_PIN_FOUR_OUT = r_reg.sck;
   assign GEN_PIN_FOUR_OE = mode_on;
   assign GEN_PIN_FIVE_OUT = r_reg.sd_out;
   assign GEN_PIN_FIVE_OE = mode_on && r_reg.sd_oe;
   assign CTRL_RDATA = r_reg.ctrl_rd;
   assign DATA_RDATA = r_reg.data_buf;
   assign EXT_SERIAL_INT = r_reg.irq;

   // writes queue here; the queue only drains when a command takes its byte
   esm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK),
      .rst(RST),
      .in_valid(DATA_WR && CE),
      .in_ready(DATA_WR_RDY),
      .in_data(DATA_WDATA),
      .out_valid(fifo_valid),
      .out_ready(pop && CE),
      .out_data(fifo_data)
   );

   always_comb
   begin
      r_next = r_reg;
      pop = 1'b0;
      r_next.irq = 1'b0;
      r_next.div = tick ? (mode_three ? W3_RELOAD : TW_RELOAD) : 8'(r_reg.div - 8'h01);
      if (take && mode_on)
      begin
         r_next.cmd = CTRL_WDATA;
         r_next.div = mode_three ? W3_RELOAD : TW_RELOAD;
         r_next.bit_idx = 4'h0;
         r_next.step = 2'h0;
      end
      if (take && mode_three)
      begin
         r_next.state = ST_TW;
         r_next.busy = 1'b1;
         r_next.sck = 1'b0;
         r_next.sh = CTRL_WDATA[`ESM_BIT_RD] ? 8'h00 : src;
         r_next.data_buf = src;
         pop = fifo_valid && !CTRL_WDATA[`ESM_BIT_RD];
         if (CTRL_WDATA[3:0] != 4'h0)
         begin
            r_next.sd_oe = !CTRL_WDATA[`ESM_BIT_RD];
            r_next.sd_out = src[7];
         end
      end
      else if (take && mode_two)
      begin
         r_next.error = !cmd_legal(wcmd);
         case (wcmd)
            `ESM_CMD_NOP:
            begin
               r_next.clk_run = 1'b0;
               r_next.sck = 1'b1;
            end
            `ESM_CMD_START, `ESM_CMD_STOP:
            begin
               r_next.state = (wcmd == `ESM_CMD_START) ? ST_START : ST_STOP;
               r_next.busy = 1'b1;
               r_next.clk_run = 1'b0;
            end
            `ESM_CMD_TX:
            begin
               r_next.state = ST_BYTE;
               r_next.busy = 1'b1;
               r_next.sh = src;
               r_next.data_buf = src;
               pop = fifo_valid;
            end
            `ESM_CMD_RX_ACK, `ESM_CMD_RX_LAST:
            begin
               r_next.state = ST_BYTE;
               r_next.busy = 1'b1;
               r_next.sh = 8'h00;
            end
            default:
            begin
               r_next.state = r_reg.state;
            end
         endcase
      end
      else
      begin
         case (r_reg.state)
            ST_IDLE:
            begin
               if (mode_two && !r_reg.clk_run)
                  r_next.sck = 1'b1;
               else if (mode_two && tick)
               begin
                  r_next.sck = !r_reg.sck;
                  if (r_reg.sck)
                     r_next.sd_oe = 1'b0;
               end
               else if (mode_three)
                  r_next.sck = 1'b0;
            end
            ST_START:
            begin
               if (tick)
               begin
                  r_next.step = 2'(r_reg.step + 2'h1);
                  r_next.sck = 1'b1;
                  r_next.sd_out = 1'b0;
                  r_next.sd_oe = (r_reg.step != 2'h0);
                  if (r_reg.step != 2'h0)
                  begin
                     r_next.state = ST_IDLE;
                     r_next.busy = 1'b0;
                  end
               end
            end
            ST_STOP:
            begin
               // clock falls first, so pulling data low never forms a start
               if (tick)
               begin
                  r_next.step = 2'(r_reg.step + 2'h1);
                  r_next.sck = (r_reg.step >= 2'h2);
                  r_next.sd_out = 1'b0;
                  if (r_reg.step == 2'h1)
                     r_next.sd_oe = 1'b1;
                  if (r_reg.step == 2'h3)
                  begin
                     r_next.sd_oe = 1'b0;
                     r_next.state = ST_IDLE;
                     r_next.busy = 1'b0;
                  end
               end
            end
            ST_BYTE:
            begin
               if (tick && r_reg.sck)
               begin
                  r_next.sck = 1'b0;
                  r_next.sd_out = 1'b0;
                  if (r_reg.bit_idx == 4'h8)
                     r_next.sd_oe = !is_tx && rx_with_ack;
                  else
                     r_next.sd_oe = is_tx && !r_reg.sh[7];
               end
               else if (tick)
               begin
                  r_next.sck = 1'b1;
                  r_next.bit_idx = idx_inc;
                  r_next.sh = {r_reg.sh[6:0], is_tx ? 1'b0 : sda};
                  if (r_reg.bit_idx == 4'h8)
                  begin
                     r_next.sh = r_reg.sh;
                     if (is_tx)
                        r_next.rx_ack_n = sda;
                     else
                        r_next.tx_ack_n = !rx_with_ack;
                     if (!is_tx)
                        r_next.data_buf = r_reg.sh;
                     r_next.state = ST_IDLE;
                     r_next.busy = 1'b0;
                     r_next.clk_run = 1'b1;
                  end
               end
            end
            ST_TW:
            begin
               if (tw_cnt == 4'h0)
               begin
                  r_next.sd_oe = !tw_hiz;
                  r_next.state = tw_wfr ? ST_WAIT : ST_IDLE;
                  r_next.busy = tw_wfr;
               end
               else if (tick && !r_reg.sck)
               begin
                  r_next.sck = 1'b1;
                  r_next.sh = {r_reg.sh[6:0], tw_rd ? sda : 1'b0};
                  r_next.bit_idx = idx_inc;
                  if ((idx_inc == tw_cnt) && tw_hiz)
                     r_next.sd_oe = 1'b0;
               end
               else if (tick)
               begin
                  r_next.sck = 1'b0;
                  if (r_reg.bit_idx == tw_cnt)
                  begin
                     if (tw_rd)
                        r_next.data_buf = r_reg.sh;
                     r_next.state = tw_wfr ? ST_WAIT : ST_IDLE;
                     r_next.busy = tw_wfr;
                  end
                  else if (!tw_rd)
                     r_next.sd_out = r_reg.sh[7];
               end
            end
            ST_WAIT:
            begin
               if (sda_rise)
               begin
                  r_next.state = ST_IDLE;
                  r_next.busy = 1'b0;
               end
            end
            default:
            begin
               r_next.state = ST_IDLE;
               r_next.busy = 1'b0;
            end
         endcase
      end
      r_next.irq = r_reg.busy && !r_next.busy;
      r_next.ctrl_rd = mode_three ? {r_next.cmd[7], r_next.busy, r_next.cmd[5:0]} :
                       {r_next.error, r_next.busy, r_next.rx_ack_n, r_next.tx_ack_n, r_next.cmd[3:0]};
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         r_reg <= '0;
         r_reg.state <= ST_IDLE;
         r_reg.rx_ack_n <= `ESM_ACK_N_RST;
         r_reg.tx_ack_n <= `ESM_ACK_N_RST;
         r_reg.sck <= `ESM_SCK_RST;
         r_reg.ctrl_rd <= {2'b00, `ESM_ACK_N_RST, `ESM_ACK_N_RST, 4'h0};
      end
      else if (CE)
         r_reg <= r_next;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         sd_s1_reg <= 1'b1;
         sd_s2_reg <= 1'b1;
         sd_s3_reg <= 1'b1;
         sd_filt_reg <= 1'b1;
      end
      else if (CE)
      begin
         sd_s1_reg <= GEN_PIN_FIVE_IN;
         sd_s2_reg <= sd_s1_reg;
         sd_s3_reg <= sd_s2_reg;
         sd_filt_reg <= sd_filt_next;
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   property p_irq_fall;
      $fell(r_reg.busy) |-> EXT_SERIAL_INT;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("no interrupt as busy fell");

   property p_tx_launch;
      CE && take && mode_two && (wcmd == `ESM_CMD_TX) |=> r_reg.busy && (r_reg.state == ST_BYTE);
   endproperty
   a_tx_launch: assert property (p_tx_launch) else $error("transmit did not start");

   property p_illegal;
      CE && take && mode_two && !cmd_legal(wcmd) |=> r_reg.error && !r_reg.busy;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal code not flagged");

   property p_busy_ignore;
      CE && CTRL_WR && r_reg.busy |=> $stable(r_reg.cmd);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while busy");

   property p_held_high;
      CE && mode_two && (r_reg.state == ST_IDLE) && !r_reg.clk_run |=> GEN_PIN_FOUR_OUT;
   endproperty
   a_held_high: assert property (p_held_high) else $error("stopped clock not high");

   property p_free_run;
      CE && tick && !take && mode_two && (r_reg.state == ST_IDLE) && r_reg.clk_run |=> $changed(r_reg.sck);
   endproperty
   a_free_run: assert property (p_free_run) else $error("clock stopped without no-op");

   property p_ack_drive;
      (r_reg.state == ST_BYTE) && (r_reg.bit_idx == 4'h8) && !r_reg.sck && rx_with_ack
         |-> r_reg.sd_oe && !r_reg.sd_out;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack not driven on ninth clock");

   property p_cnt_zero;
      CE && take && mode_three && (wcmd == 4'h0) && !(CTRL_WDATA[7] && CTRL_WDATA[5])
         |=> r_reg.busy ##1 !r_reg.busy && !r_reg.sck && (r_reg.sd_oe == !$past(CTRL_WDATA[5], 2));
   endproperty
   a_cnt_zero: assert property (p_cnt_zero) else $error("zero count misbehaved");

   property p_wait_ready;
      CE && (r_reg.state == ST_WAIT) && !sda_rise |=> r_reg.busy;
   endproperty
   a_wait_ready: assert property (p_wait_ready) else $error("busy fell before ready edge");

   property p_float;
      CE && (r_reg.state == ST_TW) && tick && !r_reg.sck && (idx_inc == tw_cnt) && tw_hiz |=> !r_reg.sd_oe;
   endproperty
   a_float: assert property (p_float) else $error("data not floated after last rise");
endmodule : esm_eeprom_serial_master
`default_nettype wire

// File: esm_eeprom_model.sv
// esm_eeprom_model: behavioural serial eeprom on the clock and data pins
// assumes an open-drain data wire with a pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module esm_eeprom_model (
   // pins
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   // bench controls
   input wire logic cs,
   input wire logic rd_mode,
   input wire logic ack_en,
   input wire logic hold_low,
   input wire logic [7:0] rd_byte,
   output logic [7:0] got
);
   int cnt = 0;
   logic q = 1'b1;
   logic ack_q = 1'b0;
   initial got = 8'h00;
   always @(negedge sda) if (scl === 1'b1) cnt = 0;
   always @(negedge cs) cnt = 0;
   // idle low clock means three-wire: first bit shown before first rise
   always @(posedge rd_mode) if (scl === 1'b0) q = rd_byte[7];
   always @(posedge scl)
   begin
      if (cnt < 8) got = {got[6:0], sda};
      cnt = (cnt < 8) ? cnt + 1 : 0;
   end
   always @(negedge scl)
   begin
      ack_q = (cnt == 8) && !rd_mode && ack_en;
      q = (cnt < 8) ? rd_byte[7 - cnt] : 1'b1;
   end
   assign sda_pull = ack_q || hold_low || (rd_mode && !q);
endmodule : esm_eeprom_model
`default_nettype wire

// File: testbench.sv
// testbench: self-checking bench for the eeprom serial master
// assumes the design files and esm_eeprom_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [7:0] cmd, din, mask, stat, dexp; logic ack;} esm_row_s;
   esm_row_s rows [4] = '{
      '{8'h03, 8'ha5, 8'hef, 8'h03, 8'ha5, 1'b1},
      '{8'h03, 8'h3c, 8'hef, 8'h23, 8'h3c, 1'b0},
      '{8'h02, 8'h96, 8'hdf, 8'h02, 8'h96, 1'b0},
      '{8'h06, 8'h5a, 8'hdf, 8'h16, 8'h5a, 1'b0}};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [1:0] sel = 2'h0;
   logic ctrl_wr = 1'b0;
   logic [7:0] ctrl_wdata = 8'h00;
   logic data_wr = 1'b0;
   logic [7:0] data_wdata = 8'h00;
   logic cs = 1'b1, rd_mode = 1'b0, ack_en = 1'b1, hold_low = 1'b0;
   logic [7:0] rd_byte = 8'h00;
   wire logic [7:0] ctrl_rdata, data_rdata, got;
   wire logic rdy, sck, sck_oe, sd_out, sd_oe, irq, pull, sda;
   int n_mismatch = 0, comparisons = 0, n_rise = 0, n_start = 0, n_stop = 0, n;
   time t_rise = 0, period = 0;
   // wired-and data line with pull-up
   assign sda = !((sd_oe && !sd_out) || pull);
   esm_eeprom_serial_master dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .PIN_FUNC_SEL(sel),
      .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata), .CTRL_RDATA(ctrl_rdata), .DATA_WR(data_wr),
      .DATA_WDATA(data_wdata), .DATA_WR_RDY(rdy), .DATA_RDATA(data_rdata), .GEN_PIN_FOUR_OUT(sck),
      .GEN_PIN_FOUR_OE(sck_oe), .GEN_PIN_FIVE_IN(sda), .GEN_PIN_FIVE_OUT(sd_out),
      .GEN_PIN_FIVE_OE(sd_oe), .EXT_SERIAL_INT(irq));
   esm_eeprom_model eeprom (.scl(sck), .sda(sda), .sda_pull(pull), .cs(cs), .rd_mode(rd_mode),
      .ack_en(ack_en), .hold_low(hold_low), .rd_byte(rd_byte), .got(got));
   always #50 ref_clk = ~ref_clk;
   always @(posedge sck)
   begin
      n_rise++;
      period = $time - t_rise;
      t_rise = $time;
   end
   always @(negedge sda) if (sck === 1'b1) n_start++;
   always @(posedge sda) if (sck === 1'b1) n_stop++;
   task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
      comparisons++;
      if (got_v !== exp_v)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic ctrl(input logic [7:0] v);
      @(posedge ref_clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= v;
      @(posedge ref_clk);
      ctrl_wr <= 1'b0;
      #1;
   endtask : ctrl
   task automatic dwr(input logic [7:0] v);
      @(posedge ref_clk);
      data_wr <= 1'b1;
      data_wdata <= v;
      @(posedge ref_clk);
      data_wr <= 1'b0;
   endtask : dwr
   // bounded wait; a hang leaves the interrupt low and is caught
   task automatic done_wait;
      int k;
      k = 0;
      check({7'h0, ctrl_rdata[6]}, 8'h01);
      while (ctrl_rdata[6] !== 1'b0 && k < 3000)
      begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      check({7'h0, irq}, 8'h01);
   endtask : done_wait
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   initial
   begin
      #3_000_000;
      n_mismatch++;
      results();
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(1);
      check(ctrl_rdata, 8'h30);
      check(data_rdata, 8'h00);
      check({4'h0, sck, sd_oe, irq, rdy}, 8'h09);
      check({7'h0, sck_oe}, 8'h00);
      @(posedge ref_clk);
      sel <= 2'h1;
      cyc(2);
      check({6'h0, sck_oe, sd_oe}, 8'h02);
      $display("done: reset");
      n = n_start;
      ctrl(8'h09);
      done_wait();
      check(8'(n_start - n), 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         ack_en = rows[i].ack;
         rd_byte = rows[i].din;
         rd_mode = (rows[i].cmd != 8'h03);
         if (!rd_mode) dwr(rows[i].din);
         ctrl(rows[i].cmd);
         done_wait();
         check(ctrl_rdata & rows[i].mask, rows[i].stat);
         check(rd_mode ? data_rdata : got, rows[i].dexp);
         ctrl(8'h00);
         rd_mode = 1'b0;
      end
      n = n_stop;
      ctrl(8'h05);
      done_wait();
      check(8'(n_stop - n), 8'h01);
      $display("done: two-wire rows");
      ack_en = 1'b1;
      ctrl(8'h09);
      done_wait();
      @(posedge ref_clk);
      data_wr <= 1'b1;
      data_wdata <= 8'h11;
      @(posedge ref_clk);
      data_wdata <= 8'h22;
      @(posedge ref_clk);
      data_wdata <= 8'h33;
      #1;
      check({7'h0, rdy}, 8'h00);
      @(posedge ref_clk);
      data_wr <= 1'b0;
      ctrl(8'h03);
      cyc(5);
      n = n_start;
      ctrl(8'h09);
      done_wait();
      check(got, 8'h11);
      check(ctrl_rdata & 8'h4f, 8'h03);
      check(8'(n_start - n), 8'h00);
      ctrl(8'h03);
      done_wait();
      check(got, 8'h22);
      check({7'h0, rdy}, 8'h01);
      n = n_rise;
      cyc(300);
      check(8'(n_rise - n >= 2), 8'h01);
      check(8'(period / 100), 8'h80);
      // enable low freezes the running clock
      @(posedge ref_clk);
      ce <= 1'b0;
      n = n_rise;
      cyc(300);
      check(8'(n_rise - n), 8'h00);
      @(posedge ref_clk);
      ce <= 1'b1;
      ctrl(8'h00);
      cyc(2);
      n = n_rise;
      cyc(300);
      check({8'(n_rise - n)} | {7'h0, !sck}, 8'h00);
      $display("done: buffer and clock");
      n = n_rise;
      for (int c = 0; c < 16; c++)
      begin
         if (!(c inside {0, 2, 3, 5, 6, 9}))
         begin
            ctrl(8'(c));
            cyc(2);
            check(ctrl_rdata & 8'hc0, 8'h80);
         end
      end
      check(8'(n_rise - n), 8'h00);
      ctrl(8'h00);
      cyc(2);
      check(ctrl_rdata & 8'h80, 8'h00);
      $display("done: illegal codes");
      @(posedge ref_clk);
      sel <= 2'h3;
      ack_en = 1'b0;
      cs = 1'b0;
      cyc(2);
      cs = 1'b1;
      dwr(8'hc3);
      ctrl(8'h08);
      done_wait();
      check(got, 8'hc3);
      check(8'(period / 100), 8'h14);
      cs = 1'b0;
      cyc(2);
      cs = 1'b1;
      dwr(8'ha8);
      ctrl(8'h25);
      done_wait();
      check(got & 8'h1f, 8'h15);
      check({7'h0, sd_oe}, 8'h00);
      cs = 1'b0;
      cyc(2);
      cs = 1'b1;
      rd_byte = 8'hb4;
      rd_mode = 1'b1;
      ctrl(8'h16);
      done_wait();
      check(data_rdata, 8'h2d);
      cs = 1'b0;
      rd_mode = 1'b0;
      n = n_rise;
      ctrl(8'h00);
      done_wait();
      check({7'h0, sd_oe}, 8'h01);
      check(8'(n_rise - n), 8'h00);
      cs = 1'b1;
      hold_low = 1'b1;
      dwr(8'hff);
      ctrl(8'ha8);
      cyc(400);
      check({7'h0, ctrl_rdata[6]}, 8'h01);
      hold_low = 1'b0;
      done_wait();
      cs = 1'b0;
      $display("done: three-wire");
      results();
   end
endmodule : testbench
`default_nettype wire
